// File: src/lbb_bridge.sv
`timescale 1ns/1ps
`include "lbb_cfg.svh"

module lbb_bridge (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Static configuration
  input  wire logic        mode_16bit,
  input  wire logic        halt_n,
  // Host bus
  input  wire logic        host_ts,
  input  wire logic [31:0] host_ad_in,
  input  wire logic        access_type_mux_signal,
  input  wire logic [1:0]  host_tt,
  input  wire logic [1:0]  host_siz,
  input  wire logic        host_rnw,
  output logic      [31:0] host_ad_out,
  output logic             host_ad_oe,
  output logic             host_ta,
  output logic             transfer_burst_inhibit,
  output logic             auto_acknowledge_select,
  // Legacy bus control
  output logic             leg_as_n,
  output logic             leg_uds_n,
  output logic             leg_lds_n,
  output logic             leg_rnw,
  output logic      [2:0]  function_code_lines,
  output logic             leg_ctrl_oe,
  input  wire logic        leg_dtack_n,
  // Legacy address and data
  output logic      [23:1] leg_addr,
  output logic             leg_addr_oe,
  input  wire logic [15:0] leg_data_in,
  output logic      [15:0] leg_data_out,
  output logic             leg_data_oe,
  // Status
  output logic             bridge_halted
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] beat_count(input logic [1:0] siz, input logic m16);
    case (siz)
      `LBB_SIZ_BYTE: beat_count = `LBB_BEATS_1;
      `LBB_SIZ_WORD: beat_count = m16 ? `LBB_BEATS_1 : `LBB_BEATS_2;
      `LBB_SIZ_LONG: beat_count = m16 ? `LBB_BEATS_2 : `LBB_BEATS_4;
      default:       beat_count = m16 ? `LBB_BEATS_8 : `LBB_BEATS_16;
    endcase
  endfunction

  // Beats that make up one host acknowledge; a line fill acknowledges per longword.
  function automatic logic [4:0] beats_per_ack(input logic [1:0] siz, input logic m16);
    if (siz == `LBB_SIZ_LINE) begin
      beats_per_ack = m16 ? `LBB_BEATS_2 : `LBB_BEATS_4;
    end else begin
      beats_per_ack = beat_count(siz, m16);
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  lbb_pkg::lbb_state_e state_r, state_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [4:0]  beats_r, beats_nxt;
  logic [4:0]  ack_left_r, ack_left_nxt;
  logic [1:0]  siz_r, siz_nxt;
  logic        rnw_r, rnw_nxt;
  logic        sup_r, sup_nxt;
  logic        iack_r, iack_nxt;
  logic [2:0]  level_r, level_nxt;
  logic        need_wdata_r, need_wdata_nxt;
  logic        halted_r, halted_nxt;
  logic        as_n_r, as_n_nxt;
  logic        uds_n_r, uds_n_nxt;
  logic        lds_n_r, lds_n_nxt;
  logic        ldoe_r, ldoe_nxt;
  logic [15:0] ldout_r, ldout_nxt;
  logic        ta_r, ta_nxt;
  logic [31:0] hdout_r, hdout_nxt;
  logic        hdoe_r, hdoe_nxt;

  logic        byte_beat;
  logic        last_beat;
  logic        ack_beat;
  logic [15:0] beat_wdata;
  logic [31:0] host_word;

  assign byte_beat = !mode_16bit || (siz_r == `LBB_SIZ_BYTE);
  assign last_beat = (beats_r == `LBB_BEATS_1);
  assign ack_beat  = (ack_left_r == `LBB_BEATS_1);

  // Data for the host lines, replicated over the lanes so any byte lane sees it.
  always_comb begin
    case (siz_r)
      `LBB_SIZ_BYTE: host_word = {4{rdata_r[7:0]}};
      `LBB_SIZ_WORD: host_word = {2{rdata_r[15:0]}};
      default:       host_word = rdata_r;
    endcase
  end

  always_comb begin
    if (need_wdata_r) begin
      beat_wdata = byte_beat ? {2{host_ad_in[31:24]}} : host_ad_in[31:16];
    end else begin
      beat_wdata = byte_beat ? {2{wdata_r[31:24]}} : wdata_r[31:16];
    end
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  // Counting from the host start clock: the legacy cycle spans four clocks, a
  // non-final write beat takes one extra clock, a non-final read beat two, and the final beat two more.
  always_comb begin
    state_nxt      = state_r;
    addr_nxt       = addr_r;
    wdata_nxt      = wdata_r;
    rdata_nxt      = rdata_r;
    beats_nxt      = beats_r;
    ack_left_nxt   = ack_left_r;
    siz_nxt        = siz_r;
    rnw_nxt        = rnw_r;
    sup_nxt        = sup_r;
    iack_nxt       = iack_r;
    level_nxt      = level_r;
    need_wdata_nxt = need_wdata_r;
    halted_nxt     = halted_r;
    as_n_nxt       = as_n_r;
    uds_n_nxt      = uds_n_r;
    lds_n_nxt      = lds_n_r;
    ldoe_nxt       = ldoe_r;
    ldout_nxt      = ldout_r;
    ta_nxt         = 1'b0;
    hdout_nxt      = hdout_r;
    hdoe_nxt       = 1'b0;
    case (state_r)
      lbb_pkg::LBB_IDLE: begin
        halted_nxt = !halt_n;
        if (halt_n && host_ts) begin
          addr_nxt       = host_ad_in[23:0];
          level_nxt      = host_ad_in[4:2];
          sup_nxt        = access_type_mux_signal;
          iack_nxt       = (host_tt == `LBB_TT_IACK);
          siz_nxt        = host_siz;
          rnw_nxt        = host_rnw;
          beats_nxt      = beat_count(host_siz, mode_16bit);
          ack_left_nxt   = beats_per_ack(host_siz, mode_16bit);
          need_wdata_nxt = !host_rnw;
          rdata_nxt      = 32'h0000_0000;
          as_n_nxt       = 1'b0;
          state_nxt      = lbb_pkg::LBB_ASRT;
        end
      end
      lbb_pkg::LBB_NEXT: begin
        as_n_nxt  = 1'b0;
        state_nxt = lbb_pkg::LBB_ASRT;
      end
      lbb_pkg::LBB_ASRT: begin
        // Write data follows the one-clock address phase on the same lines.
        if (need_wdata_r) begin
          wdata_nxt      = host_ad_in;
          need_wdata_nxt = 1'b0;
        end
        uds_n_nxt = byte_beat && addr_r[0];
        lds_n_nxt = byte_beat && !addr_r[0];
        ldoe_nxt  = !rnw_r;
        ldout_nxt = beat_wdata;
        state_nxt = lbb_pkg::LBB_WAIT;
      end
      lbb_pkg::LBB_WAIT: begin
        if (!leg_dtack_n) begin
          state_nxt = lbb_pkg::LBB_LATCH;
        end
      end
      lbb_pkg::LBB_LATCH: begin
        if (rnw_r) begin
          if (!byte_beat) begin
            rdata_nxt = {rdata_r[15:0], leg_data_in};
          end else begin
            rdata_nxt = {rdata_r[23:0], addr_r[0] ? leg_data_in[7:0] : leg_data_in[15:8]};
          end
        end
        as_n_nxt  = 1'b1;
        uds_n_nxt = 1'b1;
        lds_n_nxt = 1'b1;
        state_nxt = lbb_pkg::LBB_ENDC;
      end
      lbb_pkg::LBB_ENDC: begin
        ldoe_nxt     = 1'b0;
        beats_nxt    = beats_r - `LBB_BEATS_1;
        ack_left_nxt = ack_beat ? beats_per_ack(siz_r, mode_16bit) : ack_left_r - `LBB_BEATS_1;
        addr_nxt     = addr_r + (byte_beat ? `LBB_STEP_8 : `LBB_STEP_16);
        if (!rnw_r) begin
          wdata_nxt = byte_beat ? {wdata_r[23:0], 8'h00} : {wdata_r[15:0], 16'h0000};
        end
        if (last_beat || rnw_r) begin
          state_nxt = lbb_pkg::LBB_TAIL1;
        end else begin
          // A write beat that ends a longword of a line acknowledges here.
          ta_nxt         = ack_beat;
          need_wdata_nxt = ack_beat;
          state_nxt      = lbb_pkg::LBB_NEXT;
        end
      end
      lbb_pkg::LBB_TAIL1: begin
        if (beats_r == 5'h00) begin
          ta_nxt    = 1'b1;
          hdoe_nxt  = rnw_r;
          hdout_nxt = host_word;
          state_nxt = lbb_pkg::LBB_TAIL2;
        end else begin
          // Non-final read beat; a longword boundary hands the word over now.
          ta_nxt    = (ack_left_r == beats_per_ack(siz_r, mode_16bit));
          hdoe_nxt  = ta_nxt;
          hdout_nxt = rdata_r;
          state_nxt = lbb_pkg::LBB_NEXT;
        end
      end
      lbb_pkg::LBB_TAIL2: begin
        // Halt is honoured only here and in LBB_IDLE, so a split access is never left half done.
        halted_nxt = !halt_n;
        state_nxt  = lbb_pkg::LBB_IDLE;
      end
      default: begin
        state_nxt = lbb_pkg::LBB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r      <= lbb_pkg::LBB_IDLE;
      addr_r       <= 24'h000000;
      wdata_r      <= 32'h0000_0000;
      rdata_r      <= 32'h0000_0000;
      beats_r      <= 5'h00;
      ack_left_r   <= 5'h00;
      siz_r        <= 2'h0;
      rnw_r        <= 1'b1;
      sup_r        <= 1'b0;
      iack_r       <= 1'b0;
      level_r      <= 3'h0;
      need_wdata_r <= 1'b0;
      halted_r     <= 1'b0;
      as_n_r       <= 1'b1;
      uds_n_r      <= 1'b1;
      lds_n_r      <= 1'b1;
      ldoe_r       <= 1'b0;
      ldout_r      <= 16'h0000;
      ta_r         <= 1'b0;
      hdout_r      <= 32'h0000_0000;
      hdoe_r       <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      addr_r       <= addr_nxt;
      wdata_r      <= wdata_nxt;
      rdata_r      <= rdata_nxt;
      beats_r      <= beats_nxt;
      ack_left_r   <= ack_left_nxt;
      siz_r        <= siz_nxt;
      rnw_r        <= rnw_nxt;
      sup_r        <= sup_nxt;
      iack_r       <= iack_nxt;
      level_r      <= level_nxt;
      need_wdata_r <= need_wdata_nxt;
      halted_r     <= halted_nxt;
      as_n_r       <= as_n_nxt;
      uds_n_r      <= uds_n_nxt;
      lds_n_r      <= lds_n_nxt;
      ldoe_r       <= ldoe_nxt;
      ldout_r      <= ldout_nxt;
      ta_r         <= ta_nxt;
      hdout_r      <= hdout_nxt;
      hdoe_r       <= hdoe_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign transfer_burst_inhibit  = 1'b1;
  assign auto_acknowledge_select = 1'b1;

  assign host_ta     = ta_r;
  assign host_ad_out = hdout_r;
  assign host_ad_oe  = hdoe_r;

  assign leg_as_n            = as_n_r;
  assign leg_uds_n           = uds_n_r;
  assign leg_lds_n           = lds_n_r;
  assign leg_rnw             = rnw_r || halted_r;
  assign function_code_lines = iack_r ? `LBB_FC_IACK : {sup_r, `LBB_FC_DATA};
  assign leg_ctrl_oe         = !halted_r;
  assign leg_addr            = iack_r ? {`LBB_IACK_HIGH, level_r} : addr_r[23:1];
  assign leg_addr_oe         = !halted_r;
  assign leg_data_out        = ldout_r;
  assign leg_data_oe         = ldoe_r && !halted_r;
  assign bridge_halted       = halted_r;

endmodule

// File: src/lbb_cfg.svh
`ifndef LBB_CFG_SVH
`define LBB_CFG_SVH

// ****************************************
// Host transfer encodings
// ****************************************
`define LBB_SIZ_LONG   2'h0
`define LBB_SIZ_BYTE   2'h1
`define LBB_SIZ_WORD   2'h2
`define LBB_SIZ_LINE   2'h3
`define LBB_TT_IACK    2'h3

// ****************************************
// Beat counts per access
// ****************************************
`define LBB_BEATS_1    5'h01
`define LBB_BEATS_2    5'h02
`define LBB_BEATS_4    5'h04
`define LBB_BEATS_8    5'h08
`define LBB_BEATS_16   5'h10

// ****************************************
// Legacy bus fields and address steps
// ****************************************
`define LBB_FC_IACK    3'h7
`define LBB_FC_DATA    2'h1
`define LBB_IACK_HIGH  20'hfffff
`define LBB_ADDR_W     24
`define LBB_STEP_16    24'h000002
`define LBB_STEP_8     24'h000001

`endif

// File: src/lbb_pkg.sv
package lbb_pkg;

  typedef enum logic [2:0] {
    LBB_IDLE   = 3'b000,
    LBB_ASRT   = 3'b001,
    LBB_WAIT   = 3'b010,
    LBB_LATCH  = 3'b011,
    LBB_ENDC   = 3'b100,
    LBB_TAIL1  = 3'b101,
    LBB_TAIL2  = 3'b110,
    LBB_NEXT   = 3'b111
  } lbb_state_e;

endpackage

// File: verif/lbb_bridge_props.sv
`timescale 1ns/1ps
`include "lbb_cfg.svh"
module lbb_bridge_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Host side
  input wire logic        halt_n,
  input wire logic        host_ts,
  input wire logic [31:0] host_ad_in,
  input wire logic        access_type_mux_signal,
  input wire logic [1:0]  host_tt,
  input wire logic [1:0]  host_siz,
  input wire logic        host_ta,
  input wire logic        transfer_burst_inhibit,
  input wire logic        auto_acknowledge_select,
  // Legacy side
  input wire logic        leg_as_n,
  input wire logic        leg_uds_n,
  input wire logic        leg_lds_n,
  input wire logic        leg_rnw,
  input wire logic [2:0]  function_code_lines,
  input wire logic        leg_ctrl_oe,
  input wire logic [23:1] leg_addr,
  input wire logic        leg_addr_oe,
  input wire logic        leg_data_oe,
  input wire logic        bridge_halted
);
  logic       busy_r, iack_r, atm_r;
  logic [2:0] lvl_r, tac_r, rise_r;
  logic [1:0] siz_r;
  logic       start;
  assign start = host_ts && !busy_r && halt_n && !bridge_halted;
  // A line fill acks four times, so busy only drops on the last of them.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      iack_r <= 1'b0;
      atm_r  <= 1'b0;
      lvl_r  <= 3'h0;
      tac_r  <= 3'h0;
      siz_r  <= 2'h0;
      rise_r <= 3'h7;
    end else begin
      if (start) begin
        busy_r <= 1'b1;
        iack_r <= host_tt == `LBB_TT_IACK;
        atm_r  <= access_type_mux_signal;
        lvl_r  <= host_ad_in[4:2];
        siz_r  <= host_siz;
        tac_r  <= 3'h0;
      end else if (host_ta) begin
        tac_r <= tac_r + 3'h1;
        if (siz_r != `LBB_SIZ_LINE || tac_r == 3'h3) begin
          busy_r <= 1'b0;
        end
      end
      rise_r <= $rose(leg_as_n) ? 3'h0 : (rise_r == 3'h7 ? 3'h7 : rise_r + 3'h1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  start_delay_a: assert property (start |=> !leg_as_n) else $error("legacy cycle late");
  fcode_a: assert property ($fell(leg_as_n) |-> function_code_lines == (iack_r ? 3'h7 : {atm_r, 2'b01}))
    else $error("function code wrong");
  ack_tail_a: assert property (host_ta |-> leg_as_n && ($rose(leg_as_n) || rise_r <= 3'h1))
    else $error("host ack too late");
  min_cycle_a: assert property ($fell(leg_as_n) |-> !leg_as_n [*3]) else $error("legacy cycle short");
  tbi_held_a: assert property (transfer_burst_inhibit) else $error("burst allowed");
  aa_held_a: assert property (auto_acknowledge_select) else $error("autoack dropped");
  iack_level_a: assert property ($fell(leg_as_n) && iack_r |-> leg_addr == {20'hfffff, lvl_r})
    else $error("iack level misrouted");
  halt_park_a: assert property (bridge_halted |-> !leg_ctrl_oe && !leg_addr_oe && !leg_data_oe && leg_rnw)
    else $error("halt not parked");
  reset_idle_a: assert property ($fell(rst) |-> leg_as_n && leg_uds_n && leg_lds_n && !host_ta)
    else $error("not idle after reset");
  cover property (host_ta && siz_r == `LBB_SIZ_LINE && tac_r == 3'h3);
  cover property (start && host_tt == `LBB_TT_IACK);
  cover property (bridge_halted);
endmodule

// File: verif/lbb_legacy_mem.sv
`timescale 1ns/1ps
module lbb_legacy_mem (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Legacy bus
  input wire logic        leg_as_n,
  input wire logic        leg_uds_n,
  input wire logic        leg_lds_n,
  input wire logic        leg_rnw,
  input wire logic [23:1] leg_addr,
  input wire logic [15:0] leg_data_out,
  input wire logic [3:0]  wait_cyc,
  output logic            leg_dtack_n,
  output logic     [15:0] leg_data_in
);
  logic [15:0] mem [256];
  logic [15:0] last_r;
  logic [3:0]  cnt_r;
  logic        strb;
  assign strb = !leg_as_n && !(leg_uds_n && leg_lds_n);
  // Wait states count from the strobe, so a slow memory stretches every transaction.
  assign leg_dtack_n = !(strb && cnt_r >= wait_cyc);
  // A released bus shows a changing pattern: each clock inverts the value seen the clock before.
  assign leg_data_in = (strb && leg_rnw) ? mem[leg_addr[8:1]] : ~last_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= 4'h0;
      last_r <= 16'h0;
    end else begin
      cnt_r  <= strb ? cnt_r + 4'h1 : 4'h0;
      last_r <= leg_data_in;
      if (strb && !leg_rnw && !leg_dtack_n) begin
        if (!leg_uds_n) mem[leg_addr[8:1]][15:8] <= leg_data_out[15:8];
        if (!leg_lds_n) mem[leg_addr[8:1]][7:0] <= leg_data_out[7:0];
      end
    end
  end
endmodule

// File: verif/test_lbb_bridge.sv
`timescale 1ns/1ps
`include "lbb_cfg.svh"
module test_lbb_bridge;
  logic        clk = 1'b0, rst = 1'b1, mode_16bit = 1'b1, halt_n = 1'b1, host_ts = 1'b0;
  logic        access_type_mux_signal = 1'b0, host_rnw = 1'b1;
  logic [31:0] host_ad_in = 32'h0;
  logic [1:0]  host_tt = 2'h0, host_siz = 2'h0;
  logic [3:0]  wait_cyc = 4'h0;
  logic [31:0] host_ad_out;
  logic        host_ad_oe, host_ta, transfer_burst_inhibit, auto_acknowledge_select, bridge_halted;
  logic        leg_as_n, leg_uds_n, leg_lds_n, leg_rnw, leg_ctrl_oe, leg_dtack_n, leg_addr_oe, leg_data_oe;
  logic [2:0]  function_code_lines;
  logic [23:1] leg_addr;
  logic [15:0] leg_data_in, leg_data_out;
  int          n_mismatch = 0, comparisons = 0;
  lbb_bridge DUT (.*);
  lbb_legacy_mem u_mem (.*);
  always #10 clk = ~clk;
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Clocks count from the one presenting the start strobe to the one showing the final ack, both included.
  task automatic op(input string nm, input logic [1:0] tt, siz, input logic rnw, input logic [31:0] adr, wd,
                    input int nta, input logic [31:0] eclk, erd);
    int          k;
    int          got;
    logic [31:0] rd;
    k = 0;
    got = 0;
    rd = 32'h0;
    @(posedge clk);
    host_ts <= 1'b1;
    host_tt <= tt;
    host_siz <= siz;
    host_rnw <= rnw;
    host_ad_in <= adr;
    while (got < nta && k < 200) begin
      @(posedge clk);
      host_ts <= 1'b0;
      host_ad_in <= wd;
      k++;
      #1;
      if (host_ta === 1'b1) begin
        got++;
        rd = host_ad_out;
        chk({nm, " read enable"}, {31'h0, rnw}, {31'h0, host_ad_oe});
      end
    end
    if (got < nta) begin
      n_mismatch++;
      $display("[ERR] %s acks expected %0d seen %0d", nm, nta, got);
      final_report();
    end
    if (eclk != 32'h0) chk({nm, " clocks"}, eclk, k + 1);
    if (rnw && erd != 32'h0) chk({nm, " data"}, erd, rd);
  endtask
  task automatic t_mode16;
    mode_16bit <= 1'b1;
    op("long write", 2'h0, `LBB_SIZ_LONG, 1'b0, 32'hab000010, 32'h11223344, 1, 32'd12, 32'h0);
    op("long read", 2'h0, `LBB_SIZ_LONG, 1'b1, 32'h00000010, 32'h0, 1, 32'd13, 32'h11223344);
    op("byte read", 2'h0, `LBB_SIZ_BYTE, 1'b1, 32'h00000011, 32'h0, 1, 32'd7, 32'h22222222);
    op("word write", 2'h0, `LBB_SIZ_WORD, 1'b0, 32'h00000014, 32'h55665566, 1, 32'd7, 32'h0);
    op("word read", 2'h0, `LBB_SIZ_WORD, 1'b1, 32'h00000014, 32'h0, 1, 32'd7, 32'h55665566);
    op("line write", 2'h0, `LBB_SIZ_LINE, 1'b0, 32'h00000040, 32'h5a5aa5a5, 4, 32'd42, 32'h0);
    op("line read", 2'h0, `LBB_SIZ_LINE, 1'b1, 32'h00000040, 32'h0, 4, 32'd49, 32'h5a5aa5a5);
    $display("t_mode16 done");
  endtask
  task automatic t_mode8;
    mode_16bit <= 1'b0;
    op("w8 write", 2'h0, `LBB_SIZ_WORD, 1'b0, 32'h00000020, 32'h77887788, 1, 32'd12, 32'h0);
    op("b8 read", 2'h0, `LBB_SIZ_BYTE, 1'b1, 32'h00000021, 32'h0, 1, 32'd7, 32'h88888888);
    op("w8 read", 2'h0, `LBB_SIZ_WORD, 1'b1, 32'h00000020, 32'h0, 1, 32'd13, 32'h77887788);
    op("l8 write", 2'h0, `LBB_SIZ_LONG, 1'b0, 32'h00000024, 32'h99aabbcc, 1, 32'd22, 32'h0);
    op("l8 read", 2'h0, `LBB_SIZ_LONG, 1'b1, 32'h00000024, 32'h0, 1, 32'd25, 32'h99aabbcc);
    mode_16bit <= 1'b1;
    $display("t_mode8 done");
  endtask
  task automatic t_slow_iack;
    wait_cyc <= 4'h3;
    access_type_mux_signal <= 1'b1;
    op("slow byte", 2'h0, `LBB_SIZ_BYTE, 1'b1, 32'h00000011, 32'h0, 1, 32'd10, 32'h22222222);
    wait_cyc <= 4'h0;
    op("iack", `LBB_TT_IACK, `LBB_SIZ_BYTE, 1'b1, 32'h00000014, 32'h0, 1, 32'h0, 32'h0);
    access_type_mux_signal <= 1'b0;
    $display("t_slow_iack done");
  endtask
  task automatic t_halt;
    int seen;
    seen = 0;
    halt_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("bridge_halted", 32'h1, {31'h0, bridge_halted});
    @(posedge clk);
    host_ts <= 1'b1;
    @(posedge clk);
    host_ts <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (host_ta !== 1'b0 || leg_as_n !== 1'b1) seen++;
    end
    chk("activity while halted", 32'h0, seen);
    halt_n <= 1'b1;
    repeat (3) @(posedge clk);
    $display("t_halt done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("idle strobes", 32'h7, {29'h0, leg_as_n, leg_uds_n, leg_lds_n});
    t_mode16();
    t_mode8();
    t_slow_iack();
    t_halt();
    final_report();
  end
endmodule
bind lbb_bridge lbb_bridge_props u_props (.*);
